// [sssp_map.vh]
// Register offsets, field positions and reset values of the serial slave port.
`ifndef SSSP_MAP_VH
`define SSSP_MAP_VH
`define SSSP_ADDR_W          12
`define SSSP_OFF_RX_STATUS   12'h000
`define SSSP_OFF_TX_BUF      12'h004
`define SSSP_OFF_TX_STATUS   12'h008
`define SSSP_OFF_BAUD_CTRL   12'h00C
`define SSSP_OFF_RATE_HIGH   12'h010
`define SSSP_OFF_RATE_LOW    12'h014
`define SSSP_OFF_RX_BUF      12'h018
`define SSSP_OFF_INT_CTRL    12'h01C
`define SSSP_OFF_PWR_CTRL    12'h020
// Receive status and control fields.
`define SSSP_RS_PORT_EN      7
`define SSSP_RS_RX9          6
`define SSSP_RS_SINGLE       5
`define SSSP_RS_CONT         4
`define SSSP_RS_FRAME        2
`define SSSP_RS_OVER         1
`define SSSP_RS_NINTH        0
// Transmit status and control fields.
`define SSSP_TS_CLK_SRC      7
`define SSSP_TS_TX9          6
`define SSSP_TS_TX_EN        5
`define SSSP_TS_SYNC         4
`define SSSP_TS_SR_EMPTY     1
`define SSSP_TS_NINTH        0
// Interrupt control fields.
`define SSSP_IC_RX_FLAG      3
`define SSSP_IC_TX_FLAG      2
`define SSSP_IC_RX_IE        1
`define SSSP_IC_TX_IE        0
// Power control fields.
`define SSSP_PC_SLEEP        0
`define SSSP_PC_IDLE         1
// Reset values and frame bit counts.
`define SSSP_RST_BYTE        8'h00
`define SSSP_RST_WORD        9'h000
`define SSSP_RST_CNT         4'h0
`define SSSP_BITS_8          4'h8
`define SSSP_BITS_9          4'h9
`endif

// [sssp_sync.v]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module sssp_sync
(
   // Clock and reset.
   input  wire i_clk,
   input  wire i_reset,
   // Raw and filtered level.
   input  wire i_async,
   output reg  o_level
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         s1_ff   <= 1'b0;
         s2_ff   <= 1'b0;
         s3_ff   <= 1'b0;
         o_level <= 1'b0;
      end
      else
      begin
         s1_ff <= i_async;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff)
            o_level <= s3_ff;
      end
   end
endmodule

// [sssp_shift.v]
// Shift engine driven by detected shift clock edges.
`timescale 1ns/1ps
`include "sssp_map.vh"
module sssp_shift
(
   // Clock and reset.
   input  wire       i_clk,
   input  wire       i_reset,
   // Shift clock edges and data in.
   input  wire       i_rise,
   input  wire       i_fall,
   input  wire       i_din,
   // Control.
   input  wire       i_tx_mode,
   input  wire       i_rx_mode,
   input  wire       i_nine,
   input  wire       i_load,
   input  wire [8:0] i_load_word,
   // Status and results.
   output reg        o_busy,
   output reg        o_dout,
   output reg        o_tx_done,
   output reg        o_rx_done,
   output reg  [8:0] o_rx_word
);
   reg [8:0] sr_ff;
   reg [3:0] cnt_ff;
   wire [3:0] nbits = i_nine ? `SSSP_BITS_9 : `SSSP_BITS_8;

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         sr_ff     <= `SSSP_RST_WORD;
         cnt_ff    <= `SSSP_RST_CNT;
         o_busy    <= 1'b0;
         o_dout    <= 1'b0;
         o_tx_done <= 1'b0;
         o_rx_done <= 1'b0;
         o_rx_word <= `SSSP_RST_WORD;
      end
      else
      begin
         o_tx_done <= 1'b0;
         o_rx_done <= 1'b0;
         if (i_tx_mode)
         begin
            if (i_load && !o_busy)
            begin
               o_dout <= i_load_word[0];
               sr_ff  <= {1'b0, i_load_word[8:1]};
               cnt_ff <= nbits - 4'h1;
               o_busy <= 1'b1;
            end
            else if (o_busy && i_rise)
            begin
               if (cnt_ff == `SSSP_RST_CNT)
               begin
                  o_busy    <= 1'b0;
                  o_tx_done <= 1'b1;
               end
               else
               begin
                  o_dout <= sr_ff[0];
                  sr_ff  <= {1'b0, sr_ff[8:1]};
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
         end
         else if (i_rx_mode)
         begin
            o_busy <= 1'b0;
            if (i_fall)
            begin
               if (cnt_ff == nbits - 4'h1)
               begin
                  cnt_ff    <= `SSSP_RST_CNT;
                  o_rx_done <= 1'b1;
                  if (i_nine)
                     o_rx_word <= {i_din, sr_ff[8:1]};
                  else
                     o_rx_word <= {1'b0, i_din, sr_ff[8:2]};
               end
               else
               begin
                  cnt_ff <= cnt_ff + 4'h1;
                  sr_ff  <= {i_din, sr_ff[8:1]};
               end
            end
         end
         else
         begin
            o_busy <= 1'b0;
            cnt_ff <= `SSSP_RST_CNT;
         end
      end
   end
endmodule

// [sssp_top.v]
// Synchronous slave serial port with APB register access.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "sssp_map.vh"
module sssp_top
(
   // Clock and reset.
   input  wire        i_clk,
   input  wire        i_reset,
   // APB slave.
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr,
   // Serial pins.
   input  wire        i_shift_clock_pin,
   input  wire        i_serial_data_pin,
   output reg         o_serial_data_pin,
   output reg         o_serial_data_oe,
   // Wake request.
   output reg         o_wake
);
   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   reg [7:0] rx_ctrl_ff;
   reg [7:0] tx_ctrl_ff;
   reg [7:0] baud_ff;
   reg [7:0] rate_hi_ff;
   reg [7:0] rate_lo_ff;
   reg [7:0] tx_buf_ff;
   reg       tx_buf_ninth_ff;
   reg       tx_full_ff;
   reg       tx_flag_ff;
   reg [7:0] rx_buf_ff;
   reg       rx_ninth_ff;
   reg       rx_flag_ff;
   reg       over_ff;
   reg       frame_ff;
   reg       tx_ie_ff;
   reg       rx_ie_ff;
   reg [1:0] pwr_ff;
   reg       clk_prev_ff;

   wire clk_lvl;
   wire din_lvl;
   wire sh_busy;
   wire sh_dout;
   wire tx_done;
   wire rx_done;
   wire [8:0] rx_word;

   function sel;
      input [11:0] addr;
      input [11:0] off;
      begin
         sel = (addr == off);
      end
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   sssp_sync u_clk_sync
   (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_async (i_shift_clock_pin),
      .o_level (clk_lvl)
   );

   sssp_sync u_din_sync
   (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_async (i_serial_data_pin),
      .o_level (din_lvl)
   );

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         clk_prev_ff <= 1'b0;
      else
         clk_prev_ff <= clk_lvl;
   end

   wire clk_rise = clk_lvl & ~clk_prev_ff;
   wire clk_fall = ~clk_lvl & clk_prev_ff;

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   wire port_on  = rx_ctrl_ff[`SSSP_RS_PORT_EN] & tx_ctrl_ff[`SSSP_TS_SYNC];
   // The clock source bit clear selects the external shift clock.
   wire slave    = port_on & ~tx_ctrl_ff[`SSSP_TS_CLK_SRC];
   wire cont_rx  = rx_ctrl_ff[`SSSP_RS_CONT];
   // Single receive enable is ignored; only continuous receive counts.
   wire rx_mode  = slave & cont_rx;
   wire tx_mode  = slave & ~rx_mode & tx_ctrl_ff[`SSSP_TS_TX_EN];
   wire tx9      = tx_ctrl_ff[`SSSP_TS_TX9];
   wire rx9      = rx_ctrl_ff[`SSSP_RS_RX9];
   // Sleep and idle inputs never gate the shift engine.
   wire load_req = tx_full_ff & ~sh_busy & tx_mode;

   sssp_shift u_shift
   (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_rise      (clk_rise),
      .i_fall      (clk_fall),
      .i_din       (din_lvl),
      .i_tx_mode   (tx_mode),
      .i_rx_mode   (rx_mode),
      .i_nine      (rx_mode ? rx9 : tx9),
      .i_load      (load_req),
      .i_load_word ({tx_buf_ninth_ff, tx_buf_ff}),
      .o_busy      (sh_busy),
      .o_dout      (sh_dout),
      .o_tx_done   (tx_done),
      .o_rx_done   (rx_done),
      .o_rx_word   (rx_word)
   );

   // ------------------------------------------------------------------
   // APB access
   // ------------------------------------------------------------------
   wire wr = i_psel & i_penable & i_pwrite & o_pready;
   wire rd = i_psel & i_penable & ~i_pwrite & o_pready;
   wire known = sel(i_paddr, `SSSP_OFF_RX_STATUS)
              | sel(i_paddr, `SSSP_OFF_TX_BUF)
              | sel(i_paddr, `SSSP_OFF_TX_STATUS)
              | sel(i_paddr, `SSSP_OFF_BAUD_CTRL)
              | sel(i_paddr, `SSSP_OFF_RATE_HIGH)
              | sel(i_paddr, `SSSP_OFF_RATE_LOW)
              | sel(i_paddr, `SSSP_OFF_RX_BUF)
              | sel(i_paddr, `SSSP_OFF_INT_CTRL)
              | sel(i_paddr, `SSSP_OFF_PWR_CTRL);
   wire wr_txb = wr & sel(i_paddr, `SSSP_OFF_TX_BUF);
   wire rd_rxb = rd & sel(i_paddr, `SSSP_OFF_RX_BUF);
   wire wr_rxs = wr & sel(i_paddr, `SSSP_OFF_RX_STATUS);
   wire wr_txs = wr & sel(i_paddr, `SSSP_OFF_TX_STATUS);
   wire wr_bdc = wr & sel(i_paddr, `SSSP_OFF_BAUD_CTRL);
   wire wr_rth = wr & sel(i_paddr, `SSSP_OFF_RATE_HIGH);
   wire wr_rtl = wr & sel(i_paddr, `SSSP_OFF_RATE_LOW);
   wire wr_icr = wr & sel(i_paddr, `SSSP_OFF_INT_CTRL);
   wire wr_pwr = wr & sel(i_paddr, `SSSP_OFF_PWR_CTRL);

   // ------------------------------------------------------------------
   // Status decode
   // ------------------------------------------------------------------
   wire sr_empty = ~(sh_busy | load_req);
   wire rx_take  = rx_done & (~rx_flag_ff | rd_rxb);
   wire rx_lost  = rx_done & rx_flag_ff & ~rd_rxb;

   reg [7:0] rd_mux;
   always @*
   begin
      rd_mux = `SSSP_RST_BYTE;
      if (sel(i_paddr, `SSSP_OFF_RX_STATUS))
         rd_mux = {rx_ctrl_ff[7:3], frame_ff, over_ff, rx_ninth_ff};
      else if (sel(i_paddr, `SSSP_OFF_TX_BUF))
         rd_mux = tx_buf_ff;
      else if (sel(i_paddr, `SSSP_OFF_TX_STATUS))
         rd_mux = {tx_ctrl_ff[7:2], sr_empty, tx_ctrl_ff[0]};
      else if (sel(i_paddr, `SSSP_OFF_BAUD_CTRL))
         rd_mux = baud_ff;
      else if (sel(i_paddr, `SSSP_OFF_RATE_HIGH))
         rd_mux = rate_hi_ff;
      else if (sel(i_paddr, `SSSP_OFF_RATE_LOW))
         rd_mux = rate_lo_ff;
      else if (sel(i_paddr, `SSSP_OFF_RX_BUF))
         rd_mux = rx_buf_ff;
      else if (sel(i_paddr, `SSSP_OFF_INT_CTRL))
         rd_mux = {4'h0, rx_flag_ff, tx_flag_ff, rx_ie_ff, tx_ie_ff};
      else if (sel(i_paddr, `SSSP_OFF_PWR_CTRL))
         rd_mux = {6'h00, pwr_ff};
   end

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready  <= i_psel & ~i_penable;
         o_pslverr <= i_psel & ~i_penable & ~known;
         o_prdata  <= {24'h000000, rd_mux};
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_ctrl_ff <= `SSSP_RST_BYTE;
         tx_ctrl_ff <= `SSSP_RST_BYTE;
         baud_ff    <= `SSSP_RST_BYTE;
         rate_hi_ff <= `SSSP_RST_BYTE;
         rate_lo_ff <= `SSSP_RST_BYTE;
         tx_ie_ff   <= 1'b0;
         rx_ie_ff   <= 1'b0;
         pwr_ff     <= 2'b00;
      end
      else
      begin
         if (wr_rxs)
            rx_ctrl_ff <= {i_pwdata[7:3], 3'b000};
         if (wr_txs)
            tx_ctrl_ff <= {i_pwdata[7:2], 1'b0, i_pwdata[0]};
         if (wr_bdc)
            baud_ff <= i_pwdata[7:0];
         if (wr_rth)
            rate_hi_ff <= i_pwdata[7:0];
         if (wr_rtl)
            rate_lo_ff <= i_pwdata[7:0];
         if (wr_icr)
         begin
            tx_ie_ff <= i_pwdata[`SSSP_IC_TX_IE];
            rx_ie_ff <= i_pwdata[`SSSP_IC_RX_IE];
         end
         if (wr_pwr)
            pwr_ff <= i_pwdata[1:0];
      end
   end

   // ------------------------------------------------------------------
   // Transmit buffer
   // ------------------------------------------------------------------
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         tx_buf_ff       <= `SSSP_RST_BYTE;
         tx_buf_ninth_ff <= 1'b0;
         tx_full_ff      <= 1'b0;
         tx_flag_ff      <= 1'b1;
      end
      else
      begin
         if (wr_txb)
         begin
            tx_buf_ff       <= i_pwdata[7:0];
            tx_buf_ninth_ff <= tx_ctrl_ff[`SSSP_TS_NINTH];
            tx_full_ff      <= 1'b1;
            tx_flag_ff      <= 1'b0;
         end
         else if (load_req)
         begin
            // The buffer frees only on transfer into the shifter.
            tx_full_ff <= 1'b0;
            tx_flag_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Receive buffer and flags
   // ------------------------------------------------------------------
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_buf_ff   <= `SSSP_RST_BYTE;
         rx_ninth_ff <= 1'b0;
         rx_flag_ff  <= 1'b0;
         over_ff     <= 1'b0;
         frame_ff    <= 1'b0;
      end
      else
      begin
         if (rx_take)
         begin
            rx_buf_ff   <= rx_word[7:0];
            rx_ninth_ff <= rx_word[8];
            rx_flag_ff  <= 1'b1;
         end
         else if (rd_rxb)
            rx_flag_ff <= 1'b0;
         if (!cont_rx)
         begin
            over_ff  <= 1'b0;
            frame_ff <= 1'b0;
         end
         else if (rx_lost)
            over_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Pin drive and wake
   // ------------------------------------------------------------------
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_serial_data_pin <= 1'b0;
         o_serial_data_oe  <= 1'b0;
         o_wake            <= 1'b0;
      end
      else
      begin
         o_serial_data_pin <= sh_dout;
         o_serial_data_oe  <= tx_mode;
         o_wake <= (tx_flag_ff & tx_ie_ff)
                 | (rx_flag_ff & rx_ie_ff);
      end
   end
endmodule

// [sssp_top_monitor.sv]
// Concurrent checks on the ports of the serial slave port.
`timescale 1ns/1ps
module sssp_top_monitor
(
   // Clock and reset.
   input wire        i_clk,
   input wire        i_reset,
   // APB slave.
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire        o_pready,
   input wire        o_pslverr,
   // Serial pins and wake.
   input wire        i_shift_clock_pin,
   input wire        i_serial_data_pin,
   input wire        o_serial_data_pin,
   input wire        o_serial_data_oe,
   input wire        o_wake
);
   // ----------------------------------------
   // Quiet link counter.
   // ----------------------------------------
   logic [4:0] quiet_ff;
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         quiet_ff <= 5'h00;
      else if (i_shift_clock_pin || i_psel)
         quiet_ff <= 5'h00;
      else if (quiet_ff != 5'h1F)
         quiet_ff <= quiet_ff + 5'h01;
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // ----------------------------------------
   // Assertions.
   // ----------------------------------------
   a_ready_next: assert property (i_psel && !i_penable |=> o_pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready held too long");
   a_ready_access: assert property (o_pready |-> i_psel && i_penable)
      else $error("pready outside access phase");
   a_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   a_err_unmapped: assert property (o_pready && i_paddr > 12'h020
      |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (o_pready && i_paddr <= 12'h020
      && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
      else $error("mapped access refused");
   a_rdata_upper: assert property (o_pready && !i_pwrite
      |-> o_prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_wake_reset: assert property ($fell(i_reset) |-> !o_wake [*2])
      else $error("wake without enable");
   a_wake_flags: assert property (o_pready && !i_pwrite
      && i_paddr == 12'h01C
      |-> o_wake == ((o_prdata[3] & o_prdata[1])
                   | (o_prdata[2] & o_prdata[0])))
      else $error("wake disagrees with flags");
   a_dout_still: assert property (quiet_ff >= 5'h10
      |-> $stable(o_serial_data_pin) && $stable(o_serial_data_oe))
      else $error("data out moved without shift clock");
endmodule
bind sssp_top sssp_top_monitor i_sssp_top_monitor
(
   .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_shift_clock_pin(i_shift_clock_pin),
   .i_serial_data_pin(i_serial_data_pin),
   .o_serial_data_pin(o_serial_data_pin),
   .o_serial_data_oe(o_serial_data_oe), .o_wake(o_wake)
);

// [sssp_master_model.sv]
// Behavioural external master that drives the shift clock and data.
`timescale 1ns/1ps
module sssp_master_model
(
   // Device data out.
   input  wire        i_dout,
   // Shift clock and data to the device.
   output logic       o_sck,
   output logic       o_sdo
);
   logic [8:0] rx_word;
   initial
   begin
      o_sck   = 1'b0;
      o_sdo   = 1'b0;
      rx_word = 9'h000;
   end
   // ----------------------------------------
   // One frame, LSB first; clock idles low between frames.
   // ----------------------------------------
   task automatic frame(input logic [8:0] w, input int n);
      rx_word = 9'h000;
      #37;
      for (int i = 0; i < n; i++)
      begin
         #390 rx_word[i] = i_dout;
         #10 o_sck = 1'b1;
         o_sdo = w[i];
         #400 o_sck = 1'b0;
      end
      #400 o_sdo = ~o_sdo;
   endtask
endmodule

// [sssp_top_tb_top.sv]
// Self-checking testbench of the serial slave port.
`timescale 1ns/1ps
`include "sssp_map.vh"
module sssp_top_tb_top;
   localparam logic [11:0] RXS = `SSSP_OFF_RX_STATUS;
   localparam logic [11:0] TXB = `SSSP_OFF_TX_BUF;
   localparam logic [11:0] TXS = `SSSP_OFF_TX_STATUS;
   localparam logic [11:0] RXB = `SSSP_OFF_RX_BUF;
   localparam logic [11:0] ICR = `SSSP_OFF_INT_CTRL;
   localparam logic [11:0] PWR = `SSSP_OFF_PWR_CTRL;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sck;
   logic        sdi;
   logic        sdo;
   logic        oe;
   logic        wake;
   logic [31:0] rdata;
   logic        serr;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   sssp_top i_sssp_top
   (
      .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_shift_clock_pin(sck), .i_serial_data_pin(sdi),
      .o_serial_data_pin(sdo), .o_serial_data_oe(oe), .o_wake(wake)
   );
   sssp_master_model i_sssp_master_model
   (
      .i_dout(sdo), .o_sck(sck), .o_sdo(sdi)
   );
   always #50 clk = ~clk;
   // ----------------------------------------
   // Bus tasks and checks.
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdata = prdata;
      serr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      check(rdata, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic wake_is(input logic e);
      repeat (3) @(posedge clk);
      check({31'h0, wake}, {31'h0, e});
   endtask
   task automatic send(input logic [8:0] w, input int n);
      i_sssp_master_model.frame(w, n);
      repeat (10) @(posedge clk);
   endtask
   task automatic final_report;
      $display("miscompares=%0d compares=%0d", miscompares, compares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         miscompares++;
         final_report();
      end
   end
   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(RXS, 32'h00);
      rd(TXS, 32'h02);
      rd(ICR, 32'h04);
      rd(12'h024, 32'h0);
      check({31'h0, serr}, 32'h1);
      wr(12'h030, 32'hFF);
      wr(RXS, 32'h80);
      wr(TXS, 32'h30);
      rd(TXS, 32'h32);
      check({31'h0, oe}, 32'h1);
      wr(PWR, 32'h01);
      wr(ICR, 32'h09);
      rd(ICR, 32'h05);
      wake_is(1'b1);
      wr(TXB, 32'hA5);
      rd(ICR, 32'h05);
      rd(TXS, 32'h30);
      wr(TXB, 32'h3C);
      rd(ICR, 32'h01);
      wake_is(1'b0);
      send(9'h000, 8);
      check({23'h0, i_sssp_master_model.rx_word}, 32'h0A5);
      rd(ICR, 32'h05);
      wake_is(1'b1);
      send(9'h000, 8);
      check({23'h0, i_sssp_master_model.rx_word}, 32'h03C);
      rd(TXS, 32'h32);
      wr(TXS, 32'h71);
      wr(TXB, 32'h5A);
      send(9'h000, 9);
      check({23'h0, i_sssp_master_model.rx_word}, 32'h15A);
      wr(TXS, 32'h10);
      wr(RXS, 32'hB0);
      wr(ICR, 32'h02);
      wr(PWR, 32'h02);
      send(9'h0C3, 8);
      wake_is(1'b1);
      rd(ICR, 32'h0E);
      rd(RXS, 32'hB0);
      check({31'h0, oe}, 32'h0);
      rd(RXB, 32'hC3);
      wake_is(1'b0);
      wr(RXS, 32'hD0);
      send(9'h1A5, 9);
      rd(RXS, 32'hD1);
      rd(RXB, 32'hA5);
      send(9'h0F0, 9);
      send(9'h155, 9);
      rd(RXS, 32'hD2);
      rd(RXB, 32'hF0);
      rd(RXS, 32'hD2);
      wr(RXS, 32'hC0);
      rd(RXS, 32'hC0);
      final_report();
   end
endmodule
